// ==== hdl/lice_rx_prio.v ====
// receive cause priority encoder
`timescale 1ns/100ps
`include "lice_defines.vh"

module lice_rx_prio (
  // event flags of one received character
  input wire special_i,
  input wire parity_err_i,
  input wire overrun_i,
  input wire framing_err_i,
  input wire bc_warn_i,
  input wire bcc_done_i,
  input wire bc_zero_i,
  input wire nxm_store_i,
  input wire nxm_fetch_i,
  input wire par_store_i,
  input wire par_fetch_i,
  input wire sync_line_i,
  input wire [3:0] sync_code_i,
  // encoded cause
  output reg [3:0] code_o,
  output reg valid_o
);

  always @* begin
    code_o = `LICE_RC_SPECIAL;
    valid_o = 1'b1;
    if (sync_line_i) begin
      // synchronous cards deliver their own code, passed unchanged
      code_o = sync_code_i;
    end else if (par_fetch_i) begin
      code_o = `LICE_RC_PAR_FETCH;
    end else if (par_store_i) begin
      code_o = `LICE_RC_PAR_STORE;
    end else if (nxm_fetch_i) begin
      code_o = `LICE_RC_NXM_FETCH;
    end else if (nxm_store_i) begin
      code_o = `LICE_RC_NXM_STORE;
    end else if (bc_zero_i) begin
      code_o = `LICE_RC_BCZERO;
    end else if (overrun_i) begin
      code_o = `LICE_RC_OVERRUN;
    end else if (framing_err_i) begin
      code_o = `LICE_RC_FRAMING;
    end else if (parity_err_i) begin
      code_o = `LICE_RC_PARITY;
    end else if (bcc_done_i) begin
      code_o = `LICE_RC_BCCDONE;
    end else if (bc_warn_i) begin
      code_o = `LICE_RC_BCWARN;
    end else if (special_i) begin
      code_o = `LICE_RC_SPECIAL;
    end else begin
      valid_o = 1'b0;
    end
  end

endmodule

// ==== hdl/lice_top.v ====
// line interrupt cause encoder: receive/transmit cause words and registers
//
// Functional notes
// - a character whose control byte has bit 0 set posts code 0000 with the character.
// - a parity sense opposite to the line setting posts code 0001, line in bits 8-11.
// - characters lost to receive buffer overflow post code 0010.
// - a missing stop bit on an asynchronous line posts code 0011.
// - storing the character that drains the byte count posts code 0100 with it.
// - a character arriving at zero byte count is not stored and posts 1000.
// - a memory timeout posts 1100 on store and 1101 on control byte fetch.
// - a memory parity error posts 1110 on store and 1111 on control byte fetch.
// - on asynchronous lines any combination with overrun reports overrun; the code reports a memory fault or zero byte count ahead of overrun.
// - framing with parity reports framing; parity only when it stands alone.
// - the priority scheme applies to asynchronous lines only.
// - transmit faults post 0000..0011 in bits 8-11 of the transmit status.
// - a transmit control byte fetch fault posts 1000 and records which fault.
// - select bits 0-3 choose the line that a line control load targets.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "lice_defines.vh"

module lice_top #(
  parameter NUM_LINES = 16,
  parameter LINE_W = 4
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // register port
  input wire [`LICE_ADDR_W-1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // receive character event from the line scanner
  input wire rx_evt_i,
  input wire [LINE_W-1:0] rx_line_i,
  input wire [7:0] rx_char_i,
  input wire rx_ctl_special_i,
  input wire rx_parity_err_i,
  input wire rx_overrun_i,
  input wire rx_framing_err_i,
  input wire rx_sync_line_i,
  input wire [3:0] rx_sync_code_i,
  // receive memory path outcome
  input wire rx_bc_zero_before_i,
  input wire rx_bc_zero_after_i,
  input wire rx_nxm_store_i,
  input wire rx_nxm_fetch_i,
  input wire rx_par_store_i,
  input wire rx_par_fetch_i,
  input wire rx_bcc_done_i,
  input wire [15:0] rx_bcc_i,
  // transmit fault event
  input wire tx_evt_i,
  input wire [LINE_W-1:0] tx_line_i,
  input wire tx_pri_nxm_i,
  input wire tx_pri_bcz_i,
  input wire tx_alt_nxm_i,
  input wire tx_alt_bcz_i,
  input wire tx_ctl_nxm_i,
  input wire tx_ctl_par_i,
  // outputs to the datapath
  output reg rx_store_en_o,
  output reg lcload_strobe_o,
  output reg [LINE_W-1:0] lcload_line_o,
  output reg [15:0] lcload_data_o,
  output reg irq_o
);

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam integer LCLOAD_CYC_RAW = (`LICE_LCLOAD_TIME_NS + `LICE_CLK_PERIOD_NS - 1) /
    `LICE_CLK_PERIOD_NS;
  localparam integer LCLOAD_CYC = (LCLOAD_CYC_RAW < 1) ? 1 : LCLOAD_CYC_RAW;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [15:0] rx_word_q;
  reg [15:0] rx_word_d;
  reg rx_full_q;
  reg [15:0] tx_stat_q;
  reg [15:0] tx_stat_d;
  reg [15:0] select_q;
  reg [15:0] lcload_q;
  reg lcbusy_q;
  reg [3:0] lccnt_q;
  reg [15:0] bcc_q;
  reg [1:0] lstate_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_stat_d;
  reg [2:0] irq_mask_q;
  reg [NUM_LINES-1:0] async_fmt_q;
  reg [15:0] rdata_d;

  wire [3:0] rx_code;
  wire rx_valid;
  wire rx_fault;
  wire [3:0] tx_code;
  wire tx_valid;
  wire [7:0] rx_char_sel;

  // ----------------------------------------------------------------
  // receive cause encoding
  // ----------------------------------------------------------------
  lice_rx_prio u_prio (
    .special_i(rx_ctl_special_i),
    .parity_err_i(rx_parity_err_i),
    .overrun_i(rx_overrun_i),
    .framing_err_i(rx_framing_err_i),
    .bc_warn_i(rx_bc_zero_after_i & ~rx_bc_zero_before_i),
    .bcc_done_i(rx_bcc_done_i),
    .bc_zero_i(rx_bc_zero_before_i),
    .nxm_store_i(rx_nxm_store_i),
    .nxm_fetch_i(rx_nxm_fetch_i),
    .par_store_i(rx_par_store_i),
    .par_fetch_i(rx_par_fetch_i),
    .sync_line_i(rx_sync_line_i & ~async_fmt_q[rx_line_i]),
    .sync_code_i(rx_sync_code_i),
    .code_o(rx_code),
    .valid_o(rx_valid)
  );

  assign rx_fault = rx_nxm_store_i | rx_nxm_fetch_i | rx_par_store_i | rx_par_fetch_i;

  // block check word shown as the OR of its two bytes
  assign rx_char_sel = (rx_code == `LICE_RC_BCCDONE) ? (rx_bcc_i[15:8] | rx_bcc_i[7:0]) :
    rx_char_i;

  // undefined receive codes are folded away rather than posted
  function is_defined_rx;
    input [3:0] c;
    begin
      is_defined_rx = !(c == 4'h6 || c == 4'h7 || c == 4'h9 || c == 4'ha || c == 4'hb);
    end
  endfunction

  always @* begin
    rx_word_d = rx_word_q;
    if (rx_evt_i && rx_valid && is_defined_rx(rx_code)) begin
      rx_word_d = {rx_code, rx_line_i[3:0], rx_char_sel};
    end
  end

  // ----------------------------------------------------------------
  // transmit cause encoding
  // ----------------------------------------------------------------
  assign tx_valid = tx_ctl_nxm_i | tx_ctl_par_i | tx_pri_nxm_i | tx_pri_bcz_i |
    tx_alt_nxm_i | tx_alt_bcz_i;
  assign tx_code = (tx_ctl_nxm_i | tx_ctl_par_i) ? `LICE_TC_CTL_FAULT :
    tx_pri_nxm_i ? `LICE_TC_PRI_NXM :
    tx_pri_bcz_i ? `LICE_TC_PRI_BCZ :
    tx_alt_nxm_i ? `LICE_TC_ALT_NXM :
    `LICE_TC_ALT_BCZ;

  always @* begin
    tx_stat_d = tx_stat_q;
    if (tx_evt_i && tx_valid) begin
      tx_stat_d = {4'h0, tx_code, 4'h0, tx_line_i[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // interrupt status; a read clears, a same-cycle event still sets
  // ----------------------------------------------------------------
  always @* begin
    irq_stat_d = irq_stat_q;
    if (reg_rd_i && reg_addr_i == `LICE_OFF_IRQSTAT) begin
      irq_stat_d = 3'h0;
    end
    if (rx_evt_i && rx_valid) begin
      irq_stat_d[`LICE_IRQ_RX_BIT] = 1'b1;
      if (rx_full_q && !(reg_rd_i && reg_addr_i == `LICE_OFF_RXWORD)) begin
        irq_stat_d[`LICE_IRQ_LOST_BIT] = 1'b1;
      end
    end
    if (tx_evt_i && tx_valid) begin
      irq_stat_d[`LICE_IRQ_TX_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 16'h0000;
    if (reg_addr_i == `LICE_OFF_RXWORD) begin
      rdata_d = rx_word_q;
    end else if (reg_addr_i == `LICE_OFF_TXSTAT) begin
      rdata_d = tx_stat_q;
    end else if (reg_addr_i == `LICE_OFF_SELECT) begin
      rdata_d = select_q;
    end else if (reg_addr_i == `LICE_OFF_LCLOAD) begin
      rdata_d = {lcbusy_q, lcload_q[14:0]};
    end else if (reg_addr_i == `LICE_OFF_BCC) begin
      rdata_d = bcc_q;
    end else if (reg_addr_i == `LICE_OFF_LSTATE) begin
      rdata_d = {14'h0000, lstate_q};
    end else if (reg_addr_i == `LICE_OFF_IRQSTAT) begin
      rdata_d = {13'h0000, irq_stat_q};
    end else if (reg_addr_i == `LICE_OFF_IRQMASK) begin
      rdata_d = {13'h0000, irq_mask_q};
    end else if (reg_addr_i == `LICE_OFF_CONFIG) begin
      rdata_d = async_fmt_q[15:0];
    end
  end

  // ----------------------------------------------------------------
  // sequential logic
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_word_q <= `LICE_RST_WORD;
      rx_full_q <= 1'b0;
      tx_stat_q <= `LICE_RST_WORD;
      select_q <= `LICE_RST_WORD;
      lcload_q <= `LICE_RST_WORD;
      lcbusy_q <= 1'b0;
      lccnt_q <= 4'h0;
      bcc_q <= `LICE_RST_WORD;
      lstate_q <= 2'h0;
      irq_stat_q <= 3'h0;
      irq_mask_q <= `LICE_RST_MASK;
      async_fmt_q <= {NUM_LINES{1'b0}};
      reg_rdata_o <= 16'h0000;
      rx_store_en_o <= 1'b0;
      lcload_strobe_o <= 1'b0;
      lcload_line_o <= {LINE_W{1'b0}};
      lcload_data_o <= 16'h0000;
      irq_o <= 1'b0;
    end else begin
      rx_word_q <= rx_word_d;
      tx_stat_q <= tx_stat_d;
      irq_stat_q <= irq_stat_d;
      reg_rdata_o <= reg_rd_i ? rdata_d : 16'h0000;
      irq_o <= |(irq_stat_d & irq_mask_q);
      lcload_strobe_o <= 1'b0;
      // a word not yet read is overwritten by a newer cause; lost flag tells
      if (rx_evt_i && rx_valid) begin
        rx_full_q <= 1'b1;
      end else if (reg_rd_i && reg_addr_i == `LICE_OFF_RXWORD) begin
        rx_full_q <= 1'b0;
      end
      // store only when memory path is clean and count was not already zero
      rx_store_en_o <= rx_evt_i & ~rx_bc_zero_before_i & ~rx_fault;
      if (rx_evt_i && rx_bcc_done_i) begin
        bcc_q <= rx_bcc_i;
      end
      if (tx_evt_i && (tx_ctl_nxm_i || tx_ctl_par_i)) begin
        lstate_q <= {tx_ctl_par_i, tx_ctl_nxm_i};
      end
      // load pacing: busy bit holds for the line card transfer time
      if (lcbusy_q) begin
        if (lccnt_q == 4'h0) begin
          lcbusy_q <= 1'b0;
        end else begin
          lccnt_q <= lccnt_q - 4'h1;
        end
      end
      if (reg_wr_i) begin
        if (reg_addr_i == `LICE_OFF_SELECT) begin
          // the load target is latched at the load write, so a change does not retarget it
          select_q <= reg_wdata_i;
        end else if (reg_addr_i == `LICE_OFF_LCLOAD) begin
          lcload_q <= reg_wdata_i;
          lcbusy_q <= 1'b1;
          lccnt_q <= LCLOAD_CYC[3:0] - 4'h1;
          lcload_strobe_o <= 1'b1;
          lcload_line_o <= select_q[LINE_W-1:0];
          lcload_data_o <= reg_wdata_i;
        end else if (reg_addr_i == `LICE_OFF_IRQMASK) begin
          irq_mask_q <= reg_wdata_i[2:0];
        end else if (reg_addr_i == `LICE_OFF_CONFIG) begin
          async_fmt_q <= reg_wdata_i[NUM_LINES-1:0];
        end
      end
    end
  end

endmodule

// ==== include/lice_defines.vh ====
// constants for the line interrupt cause encoder
`ifndef LICE_DEFINES_VH
`define LICE_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define LICE_ADDR_W 4
`define LICE_OFF_RXWORD 4'h0
`define LICE_OFF_TXSTAT 4'h1
`define LICE_OFF_SELECT 4'h2
`define LICE_OFF_LCLOAD 4'h3
`define LICE_OFF_BCC 4'h4
`define LICE_OFF_LSTATE 4'h5
`define LICE_OFF_IRQSTAT 4'h6
`define LICE_OFF_IRQMASK 4'h7
`define LICE_OFF_CONFIG 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LICE_CHAR_LSB 0
`define LICE_LINE_LSB 8
`define LICE_CODE_LSB 12
`define LICE_TXCODE_LSB 8
`define LICE_LCLOAD_BUSY_BIT 15
`define LICE_IRQ_RX_BIT 0
`define LICE_IRQ_TX_BIT 1
`define LICE_IRQ_LOST_BIT 2

// ----------------------------------------------------------------
// receive cause codes
// ----------------------------------------------------------------
`define LICE_RC_SPECIAL 4'h0
`define LICE_RC_PARITY 4'h1
`define LICE_RC_OVERRUN 4'h2
`define LICE_RC_FRAMING 4'h3
`define LICE_RC_BCWARN 4'h4
`define LICE_RC_BCCDONE 4'h5
`define LICE_RC_BCZERO 4'h8
`define LICE_RC_NXM_STORE 4'hc
`define LICE_RC_NXM_FETCH 4'hd
`define LICE_RC_PAR_STORE 4'he
`define LICE_RC_PAR_FETCH 4'hf

// ----------------------------------------------------------------
// transmit cause codes
// ----------------------------------------------------------------
`define LICE_TC_PRI_NXM 4'h0
`define LICE_TC_PRI_BCZ 4'h1
`define LICE_TC_ALT_NXM 4'h2
`define LICE_TC_ALT_BCZ 4'h3
`define LICE_TC_CTL_FAULT 4'h8

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define LICE_RST_WORD 16'h0000
`define LICE_RST_MASK 3'h0
`define LICE_LCLOAD_TIME_NS 160
`define LICE_CLK_PERIOD_NS 20

`endif

// ==== tb/lice_host.sv ====
// host program model on the register port
`timescale 1ns/100ps
`include "lice_defines.vh"

module lice_host (
  // clock and read data
  input wire clk_sys_i,
  input wire [15:0] reg_rdata_i,
  // register requests
  output reg [3:0] reg_addr_o = 4'h0,
  output reg [15:0] reg_wdata_o = 16'h0000,
  output reg reg_wr_o = 1'b0,
  output reg reg_rd_o = 1'b0
);
  task wr(input [3:0] a, input [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task rd(input [3:0] a, output [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask

  // a pending line load must finish before the select word moves
  task sel(input [15:0] d, output ok);
    reg [15:0] r;
    integer n;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      rd(`LICE_OFF_LCLOAD, r);
      ok = !r[`LICE_LCLOAD_BUSY_BIT];
    end
    if (ok) wr(`LICE_OFF_SELECT, d);
  endtask
endmodule

// ==== tb/lice_properties.sv ====
// assertion checker for the line interrupt cause encoder
`timescale 1ns/100ps
`include "lice_defines.vh"

module lice_checker #(
  parameter NUM_LINES = 16,
  parameter LINE_W = 4
) (
  // clock, reset and register port
  input wire clk_sys_i,
  input wire reset_i,
  input wire [`LICE_ADDR_W-1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  // receive and transmit events
  input wire rx_evt_i,
  input wire [LINE_W-1:0] rx_line_i,
  input wire rx_parity_err_i,
  input wire rx_overrun_i,
  input wire rx_framing_err_i,
  input wire rx_sync_line_i,
  input wire rx_bc_zero_before_i,
  input wire rx_nxm_store_i,
  input wire rx_nxm_fetch_i,
  input wire rx_par_store_i,
  input wire rx_par_fetch_i,
  input wire tx_evt_i,
  input wire tx_pri_nxm_i,
  input wire tx_pri_bcz_i,
  input wire tx_ctl_nxm_i,
  input wire tx_ctl_par_i,
  // datapath outputs
  input wire rx_store_en_o,
  input wire lcload_strobe_o,
  input wire [LINE_W-1:0] lcload_line_o,
  input wire [15:0] lcload_data_o
);
  reg [15:0] sel_q;
  wire hi_err = rx_par_fetch_i | rx_par_store_i | rx_nxm_fetch_i | rx_nxm_store_i;
  // config only forces lines async, so a line flagged async is async for sure
  wire async_ev = rx_evt_i && !rx_sync_line_i && !hi_err && !rx_bc_zero_before_i;

  // mirror of the select word, used to predict the load target
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sel_q <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == `LICE_OFF_SELECT) begin
      sel_q <= reg_wdata_i;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_rd(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  property p_rx(c, k);
    c ##1 s_rd(`LICE_OFF_RXWORD) |=>
      reg_rdata_o[15:12] == k && reg_rdata_o[11:8] == $past(rx_line_i, 2);
  endproperty
  property p_tx(c, k);
    tx_evt_i && c ##1 s_rd(`LICE_OFF_TXSTAT) |=> reg_rdata_o[11:8] == k;
  endproperty

  a_overrun_wins: assert property (p_rx(async_ev && rx_overrun_i, 4'h2))
    else $error("overrun not reported as overrun");
  a_framing_wins: assert property (p_rx(async_ev && !rx_overrun_i
    && rx_framing_err_i, 4'h3))
    else $error("framing not reported as framing");
  a_parity_alone: assert property (p_rx(async_ev && !rx_overrun_i && !rx_framing_err_i
    && rx_parity_err_i, 4'h1))
    else $error("lone parity error not reported");
  a_fetch_parity: assert property (p_rx(rx_evt_i && !rx_sync_line_i
    && rx_par_fetch_i, 4'hf))
    else $error("fetch parity fault code wrong");
  a_store_nxm: assert property (p_rx(rx_evt_i && !rx_sync_line_i && rx_nxm_store_i
    && !rx_par_fetch_i && !rx_par_store_i && !rx_nxm_fetch_i, 4'hc))
    else $error("store timeout code wrong");
  a_no_undef: assert property (s_rd(`LICE_OFF_RXWORD) |=>
    !(reg_rdata_o[15:12] inside {4'h6, 4'h7, 4'h9, 4'ha, 4'hb}))
    else $error("undefined receive code posted");
  a_zero_count: assert property (rx_evt_i && rx_bc_zero_before_i |=> !rx_store_en_o)
    else $error("character stored at zero count");
  a_load_line: assert property (reg_wr_i && reg_addr_i == `LICE_OFF_LCLOAD |=>
    lcload_strobe_o && lcload_line_o == $past(sel_q[LINE_W-1:0])
    && lcload_data_o == $past(reg_wdata_i))
    else $error("line load target or data wrong");
  a_tx_count: assert property (p_tx(!tx_ctl_nxm_i && !tx_ctl_par_i && !tx_pri_nxm_i
    && tx_pri_bcz_i, 4'h1))
    else $error("transmit count fault code wrong");
  a_tx_ctl: assert property (p_tx(tx_ctl_nxm_i || tx_ctl_par_i, 4'h8))
    else $error("transmit control fault code wrong");
endmodule

bind lice_top lice_checker #(.NUM_LINES(NUM_LINES), .LINE_W(LINE_W)) u_chk (.*);

// ==== tb/tb_top.sv ====
// self-checking testbench for the line interrupt cause encoder
`timescale 1ns/100ps
`include "lice_defines.vh"

module tb_top;
  localparam [43:0] RX_TBL = 44'hfedc8231540;
  reg clk_sys_i = 1'b0, reset_i = 1'b1, rx_evt_i = 1'b0, tx_evt_i = 1'b0;
  reg rx_sync_line_i = 1'b0, irq_a = 1'b0, ok;
  reg [3:0] rx_line_i = 4'h0, tx_line_i = 4'h0, rx_sync_code_i = 4'h0, c;
  reg [7:0] rx_char_i = 8'h00;
  reg [10:0] rf = 11'h000, f;
  reg [5:0] tf = 6'h00;
  reg [15:0] rx_bcc_i = 16'h0000, v, w;
  wire [3:0] reg_addr_i;
  wire [15:0] reg_wdata_i, reg_rdata_o;
  wire reg_wr_i, reg_rd_i, irq_o;
  int err_total = 0, total_checks = 0, i;

  initial forever #10 clk_sys_i = ~clk_sys_i;

  lice_host host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  lice_top u_lice_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_evt_i(rx_evt_i), .rx_line_i(rx_line_i),
    .rx_char_i(rx_char_i), .rx_ctl_special_i(rf[0]), .rx_bc_zero_after_i(rf[1]),
    .rx_bcc_done_i(rf[2]), .rx_parity_err_i(rf[3]), .rx_framing_err_i(rf[4]),
    .rx_overrun_i(rf[5]), .rx_bc_zero_before_i(rf[6]), .rx_nxm_store_i(rf[7]),
    .rx_nxm_fetch_i(rf[8]), .rx_par_store_i(rf[9]), .rx_par_fetch_i(rf[10]),
    .rx_sync_line_i(rx_sync_line_i), .rx_sync_code_i(rx_sync_code_i), .rx_bcc_i(rx_bcc_i),
    .tx_evt_i(tx_evt_i), .tx_line_i(tx_line_i), .tx_pri_nxm_i(tf[0]), .tx_pri_bcz_i(tf[1]),
    .tx_alt_nxm_i(tf[2]), .tx_alt_bcz_i(tf[3]), .tx_ctl_nxm_i(tf[4]), .tx_ctl_par_i(tf[5]),
    .rx_store_en_o(), .lcload_strobe_o(), .lcload_line_o(), .lcload_data_o(), .irq_o(irq_o));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task chk(input [15:0] got, input [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // highest flag wins; no flag leaves the word as it was
  function automatic [15:0] exp_rx(input [10:0] fl, input [15:0] prev);
    reg [3:0] k;
    k = 4'h0;
    for (int n = 0; n < 11; n++) if (fl[n]) k = RX_TBL[4*n +: 4];
    exp_rx = (fl == 0) ? prev : {k, rx_line_i,
      (k == 4'h5) ? (rx_bcc_i[15:8] | rx_bcc_i[7:0]) : rx_char_i};
  endfunction

  // one event, then the matching cause word is read right behind it
  task ev(input t, input [10:0] fl, input s, input [3:0] sc);
    @(posedge clk_sys_i);
    if (t) begin
      tf <= fl[5:0];
      tx_evt_i <= 1'b1;
    end else begin
      rf <= fl;
      rx_evt_i <= 1'b1;
    end
    rx_sync_line_i <= s;
    rx_sync_code_i <= sc;
    {rx_line_i, rx_char_i, tx_line_i} <= 16'($urandom);
    rx_bcc_i <= 16'($urandom);
    fork
      host.rd(t ? `LICE_OFF_TXSTAT : `LICE_OFF_RXWORD, v);
      begin
        @(posedge clk_sys_i);
        rx_evt_i <= 1'b0;
        tx_evt_i <= 1'b0;
      end
    join
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    v = $urandom(32'h5c24);
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    host.rd(`LICE_OFF_RXWORD, w);
    chk(w, `LICE_RST_WORD);
    host.rd(`LICE_OFF_IRQMASK, v);
    chk(v, {13'h0, `LICE_RST_MASK});
    for (i = 0; i < 53; i++) begin
      f = (i < 11) ? 11'h1 << i : (i == 11) ? 11'h038 : (i == 12) ? 11'h018
        : 11'($urandom & $urandom & $urandom);
      ev(1'b0, f, 1'b0, 4'h0);
      w = exp_rx(f, w);
      chk(v, w);
    end
    ev(1'b0, 11'h038, 1'b1, 4'h3);
    w = {4'h3, rx_line_i, rx_char_i};
    chk(v, w);
    ev(1'b0, 11'h001, 1'b1, 4'h6);
    chk(v, w);
    host.wr(`LICE_OFF_RXWORD, 16'hffff);
    host.rd(`LICE_OFF_RXWORD, v);
    chk(v, w);
    host.wr(4'hf, 16'hffff);
    host.rd(4'hf, v);
    chk(v, 16'h0000);
    for (i = 0; i < 7; i++) begin
      f = (i < 6) ? 11'h1 << i : 11'h00e;
      ev(1'b1, f, 1'b0, 4'h0);
      c = (f[5:4] != 0) ? 4'h8 : f[0] ? 4'h0 : f[1] ? 4'h1 : f[2] ? 4'h2 : 4'h3;
      chk(v, {4'h0, c, 4'h0, tx_line_i});
      host.rd(`LICE_OFF_LSTATE, v);
      if (i > 3 && i < 6) chk(v, (i == 4) ? 16'h0001 : 16'h0002);
    end
    for (i = 0; i < 2; i++) begin
      host.rd(`LICE_OFF_IRQSTAT, v);
      host.wr(`LICE_OFF_IRQMASK, i ? 16'h0007 : 16'h0000);
      ev(1'b0, 11'h020, 1'b0, 4'h0);
      if (i) chk({15'h0, irq_a ^ irq_o}, 16'h0001);
      irq_a = irq_o;
      host.rd(`LICE_OFF_IRQSTAT, v);
      chk(v, 16'h0001);
      host.rd(`LICE_OFF_IRQSTAT, v);
      chk({v[15:1], irq_o}, 16'h0000);
    end
    host.sel(16'h0005, ok);
    chk({15'h0, ok}, 16'h0001);
    if (!ok) results();
    host.wr(`LICE_OFF_LCLOAD, 16'($urandom));
    host.rd(`LICE_OFF_LCLOAD, v);
    chk({15'h0, v[15]}, 16'h0001);
    host.sel(16'h000a, ok);
    chk({15'h0, ok}, 16'h0001);
    if (!ok) results();
    host.wr(`LICE_OFF_LCLOAD, 16'h1234);
    host.rd(`LICE_OFF_SELECT, v);
    chk(v, 16'h000a);
    results();
  end
endmodule
